//--- logic/fnc_pkg.sv
// Package of constants and types for the flash non-volatile bit controller
package fnc_pkg;
	localparam logic [7:0]  FNC_OFS_MODE     = 8'h60;
	localparam logic [7:0]  FNC_OFS_CMD      = 8'h64;
	localparam logic [7:0]  FNC_OFS_STATUS   = 8'h68;
	localparam logic [7:0]  FNC_OFS_RSVD     = 8'h6c;
	localparam logic [31:0] FNC_MODE_RESET   = 32'h0000_0000;
	localparam int          FNC_MODE_RDY_IE  = 0;
	localparam int          FNC_MODE_LOCK_IE = 2;
	localparam int          FNC_MODE_PROG_IE = 3;
	localparam int          FNC_MODE_SKIP_ER = 7;
	localparam int          FNC_MODE_WS_LO   = 8;
	localparam int          FNC_MODE_USEC_LO = 16;
	localparam logic [31:0] FNC_MODE_MASK    = 32'h00ff_038d;
	localparam int          FNC_CMD_KEY_LO   = 24;
	localparam int          FNC_CMD_PAGE_LO  = 8;
	localparam logic [7:0]  FNC_CMD_KEY      = 8'h5a;
	localparam logic [3:0]  FNC_CMD_NONE     = 4'h0;
	localparam logic [3:0]  FNC_CMD_SET_GP   = 4'hb;
	localparam logic [3:0]  FNC_CMD_CLR_GP   = 4'hd;
	localparam logic [3:0]  FNC_CMD_SET_SEC  = 4'hf;
	localparam int          FNC_ST_RDY       = 0;
	localparam int          FNC_ST_LOCK_ERR  = 2;
	localparam int          FNC_ST_PROG_ERR  = 3;
	localparam int          FNC_ST_SECURE    = 4;
	localparam int          FNC_ST_GP_LO     = 8;
	localparam int          FNC_ST_LOCKS_LO  = 16;
	localparam int          FNC_GP_BITS      = 2;
	localparam int          FNC_LOCK_BITS    = 16;
	localparam logic [3:0]  FNC_NV_USEC      = 4'h4;
	localparam logic [3:0]  FNC_ERASE_USEC   = 4'hf;
	localparam logic [1:0]  FNC_GP_ERASED    = 2'b11;
	localparam logic [15:0] FNC_LOCK_ERASED  = 16'hffff;
	typedef enum logic [1:0] {FNC_OP_SET_GP, FNC_OP_CLR_GP, FNC_OP_SET_SEC, FNC_OP_ERASE} fnc_op_t;
endpackage

//--- logic/fnc_op_if.sv
// Operation request and completion link between sequencer and nv cell store
`timescale 1ns/1ns
`default_nettype none
interface fnc_op_if;
	import fnc_pkg::*;
	logic    start;
	fnc_op_t op;
	logic [7:0] index;
	logic    done;
	modport seq (output start, output op, output index, input done);
	modport store (input start, input op, input index, output done);
endinterface
`default_nettype wire

//--- logic/fnc_nv_store.sv
// Non-volatile cell store for general-purpose, lock and security bits
`timescale 1ns/1ns
`default_nettype none
module fnc_nv_store
	import fnc_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic [7:0]               usec_cycle_count,
	fnc_op_if.store                       req,
	output logic [FNC_GP_BITS-1:0]        gp_cells,
	output logic [FNC_LOCK_BITS-1:0]      lock_cells,
	output logic                          secure_bit
);
	// GP and lock cells: 1 is the erased state, 0 the programmed state; sec_q is the reverse
	logic [FNC_GP_BITS-1:0]   gp_q, gp_d;
	logic [FNC_LOCK_BITS-1:0] lock_q, lock_d;
	logic                     sec_q, sec_d;
	logic                     busy_q, busy_d;
	fnc_op_t                  op_q, op_d;
	logic [7:0]               idx_q, idx_d;
	logic [7:0]               pre_q, pre_d;
	logic [3:0]               us_q, us_d;
	logic                     done_q, done_d;

	always_comb begin
		gp_d = gp_q;
		lock_d = lock_q;
		sec_d = sec_q;
		busy_d = busy_q;
		op_d = op_q;
		idx_d = idx_q;
		pre_d = pre_q;
		us_d = us_q;
		done_d = 1'b0;
		if (req.start && !busy_q) begin
			busy_d = 1'b1;
			op_d = req.op;
			idx_d = req.index;
			pre_d = 8'h00;
			us_d = (req.op == FNC_OP_ERASE) ? FNC_ERASE_USEC : FNC_NV_USEC;
		end else if (busy_q) begin
			// A zero count still ticks each cycle for very slow clocks
			if (pre_q + 8'h01 >= usec_cycle_count) begin
				pre_d = 8'h00;
				if (us_q == 4'h1) begin
					busy_d = 1'b0;
					done_d = 1'b1;
					case (op_q)
						FNC_OP_SET_GP: begin
							if (idx_q < 8'(FNC_GP_BITS)) gp_d[idx_q[0]] = 1'b0;
						end
						FNC_OP_CLR_GP: begin
							if (idx_q < 8'(FNC_GP_BITS)) gp_d[idx_q[0]] = 1'b1;
						end
						FNC_OP_SET_SEC: sec_d = 1'b1;
						FNC_OP_ERASE: begin
							// Security falls in the same cycle as the cells are erased
							gp_d = FNC_GP_ERASED;
							lock_d = FNC_LOCK_ERASED;
							sec_d = 1'b0;
						end
						default: ;
					endcase
				end else begin
					us_d = us_q - 4'h1;
				end
			end else begin
				pre_d = pre_q + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			gp_q <= FNC_GP_ERASED;
			lock_q <= FNC_LOCK_ERASED;
			sec_q <= 1'b0;
			busy_q <= 1'b0;
			op_q <= FNC_OP_SET_GP;
			idx_q <= 8'h00;
			pre_q <= 8'h00;
			us_q <= 4'h0;
			done_q <= 1'b0;
		end else begin
			gp_q <= gp_d;
			lock_q <= lock_d;
			sec_q <= sec_d;
			busy_q <= busy_d;
			op_q <= op_d;
			idx_q <= idx_d;
			pre_q <= pre_d;
			us_q <= us_d;
			done_q <= done_d;
		end
	end

	assign req.done = done_q;
	assign gp_cells = gp_q;
	assign lock_cells = lock_q;
	assign secure_bit = sec_q;
endmodule
`default_nettype wire

//--- logic/fnc_flash_ctrl.sv
// APB register front end and command sequencer of the flash nv bit controller
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module fnc_flash_ctrl
	import fnc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        erase_req,
	input  wire logic        array_rd_req,
	output logic             array_rd_ack,
	output logic             fc_irq,
	output logic             debug_port_en,
	output logic             fast_prog_en,
	output logic             test_port_en,
	output logic             skip_erase_sel,
	output logic [1:0]       wait_state_count,
	output logic [2:0]       rd_cycles,
	output logic [2:0]       wr_cycles
);
	fnc_op_if op_bus ();

	logic [FNC_GP_BITS-1:0]   gp_cells;
	logic [FNC_LOCK_BITS-1:0] lock_cells;
	logic                     secure_bit;

	function automatic logic cmd_known(input logic [3:0] code);
		cmd_known = (code == FNC_CMD_SET_GP) || (code == FNC_CMD_CLR_GP) ||
			(code == FNC_CMD_SET_SEC);
	endfunction

	function automatic fnc_op_t cmd_op(input logic [3:0] code);
		case (code)
			FNC_CMD_SET_GP: cmd_op = FNC_OP_SET_GP;
			FNC_CMD_CLR_GP: cmd_op = FNC_OP_CLR_GP;
			default:        cmd_op = FNC_OP_SET_SEC;
		endcase
	endfunction

	// Mapped words answer without error; the reserved slot included
	function automatic logic reg_mapped(input logic [7:0] addr);
		reg_mapped = (addr == FNC_OFS_MODE) || (addr == FNC_OFS_CMD) ||
			(addr == FNC_OFS_STATUS) || (addr == FNC_OFS_RSVD);
	endfunction

	// Register state
	logic [31:0] mode_q, mode_d;
	logic        rdy_q, rdy_d;
	logic        lock_err_q, lock_err_d;
	logic        prog_err_q, prog_err_d;
	logic        start_q, start_d;
	fnc_op_t     op_q, op_d;
	logic [7:0]  idx_q, idx_d;
	logic        erase_seen_q, erase_seen_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic        irq_q, irq_d;
	logic        rd_ack_q, rd_ack_d;
	logic        dbg_d;
	logic [2:0]  rdc_q, rdc_d;
	logic [2:0]  wrc_q, wrc_d;

	logic        access;
	logic        wr_cmd;
	logic        rd_status;
	logic [7:0]  key;
	logic [3:0]  code;
	logic [31:0] status_word;
	logic        cmd_bad;
	logic        cmd_go;
	logic        erase_go;
	logic        launch;
	logic [2:0]  port_en;

	fnc_nv_store u_store (
		.clk              (clk),
		.rst_b            (rst_b),
		.usec_cycle_count (mode_q[FNC_MODE_USEC_LO +: 8]),
		.req              (op_bus.store),
		.gp_cells         (gp_cells),
		.lock_cells       (lock_cells),
		.secure_bit       (secure_bit)
	);

	assign access = psel && penable && !pready_q;
	assign key = pwdata[FNC_CMD_KEY_LO +: 8];
	assign code = pwdata[3:0];
	assign wr_cmd = access && pwrite && (paddr == FNC_OFS_CMD);
	assign rd_status = access && !pwrite && (paddr == FNC_OFS_STATUS);
	assign cmd_bad = wr_cmd && ((key != FNC_CMD_KEY) ||
		((code != FNC_CMD_NONE) && !cmd_known(code)));
	// Commands while busy are dropped to protect the running op
	assign cmd_go = wr_cmd && (key == FNC_CMD_KEY) && cmd_known(code) && rdy_q;
	assign erase_go = erase_req && !erase_seen_q && rdy_q && !cmd_go;
	assign launch = cmd_go || erase_go;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[FNC_ST_RDY] = rdy_q;
		status_word[FNC_ST_LOCK_ERR] = lock_err_q;
		status_word[FNC_ST_PROG_ERR] = prog_err_q;
		status_word[FNC_ST_SECURE] = secure_bit;
		status_word[FNC_ST_GP_LO +: FNC_GP_BITS] = ~gp_cells;
		status_word[FNC_ST_LOCKS_LO +: FNC_LOCK_BITS] = ~lock_cells;
	end

	// Bus answer: one wait state, error only for unmapped words
	always_comb begin
		prdata_d = prdata_q;
		pready_d = access;
		pslverr_d = 1'b0;
		if (access) begin
			pslverr_d = !reg_mapped(paddr);
			if (!pwrite) begin
				case (paddr)
					FNC_OFS_MODE:   prdata_d = mode_q;
					FNC_OFS_STATUS: prdata_d = status_word;
					default:        prdata_d = 32'h0000_0000;
				endcase
			end
		end
	end

	always_comb begin
		mode_d = mode_q;
		rdy_d = rdy_q;
		lock_err_d = lock_err_q;
		prog_err_d = prog_err_q;
		// Error flags clear on read; a same-cycle set below wins
		if (rd_status) begin
			lock_err_d = 1'b0;
			prog_err_d = 1'b0;
		end
		if (access && pwrite && (paddr == FNC_OFS_MODE)) begin
			mode_d = pwdata & FNC_MODE_MASK;
		end
		if (cmd_bad) begin
			prog_err_d = 1'b1;
		end
		if (launch) begin
			rdy_d = 1'b0;
		end
		if (op_bus.done) begin
			rdy_d = 1'b1;
		end
	end

	always_comb begin
		start_d = launch;
		op_d = op_q;
		idx_d = idx_q;
		erase_seen_d = erase_req;
		if (cmd_go) begin
			op_d = cmd_op(code);
			// High page bits must not alias onto an implemented bit
			if (|pwdata[FNC_CMD_PAGE_LO + 8 +: 2]) begin
				idx_d = 8'hff;
			end else begin
				idx_d = pwdata[FNC_CMD_PAGE_LO +: 8];
			end
		end else if (erase_go) begin
			// Hardware erase request, taken on its rising edge when idle
			op_d = FNC_OP_ERASE;
			idx_d = 8'h00;
		end
	end

	always_comb begin
		irq_d = (mode_q[FNC_MODE_RDY_IE] && rdy_q) ||
			(mode_q[FNC_MODE_LOCK_IE] && lock_err_q) ||
			(mode_q[FNC_MODE_PROG_IE] && prog_err_q);
		rd_ack_d = array_rd_req;
		dbg_d = !secure_bit;
		case (mode_q[FNC_MODE_WS_LO +: 2])
			2'd0:    begin rdc_d = 3'd1; wrc_d = 3'd2; end
			2'd1:    begin rdc_d = 3'd2; wrc_d = 3'd3; end
			2'd2:    begin rdc_d = 3'd3; wrc_d = 3'd4; end
			default: begin rdc_d = 3'd4; wrc_d = 3'd4; end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mode_q <= FNC_MODE_RESET;
			rdy_q <= 1'b1;
			lock_err_q <= 1'b0;
			prog_err_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			rdy_q <= rdy_d;
			lock_err_q <= lock_err_d;
			prog_err_q <= prog_err_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			start_q <= 1'b0;
			op_q <= FNC_OP_SET_GP;
			idx_q <= 8'h00;
			// A request still high at release is not an edge
			erase_seen_q <= 1'b1;
		end else begin
			start_q <= start_d;
			op_q <= op_d;
			idx_q <= idx_d;
			erase_seen_q <= erase_seen_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
			rd_ack_q <= 1'b0;
			rdc_q <= 3'd1;
			wrc_q <= 3'd2;
		end else begin
			irq_q <= irq_d;
			rd_ack_q <= rd_ack_d;
			rdc_q <= rdc_d;
			wrc_q <= wrc_d;
		end
	end

	// One flop per blocked port, so each enable leaves from its own register
	for (genvar g = 0; g < 3; g++) begin : g_port_en
		logic en_q;
		always_ff @(posedge clk) begin
			if (!rst_b) begin
				en_q <= 1'b0;
			end else begin
				en_q <= dbg_d;
			end
		end
		assign port_en[g] = en_q;
	end

	assign op_bus.start = start_q;
	assign op_bus.op = op_q;
	assign op_bus.index = idx_q;

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign fc_irq = irq_q;
	assign array_rd_ack = rd_ack_q;
	assign debug_port_en = port_en[0];
	assign fast_prog_en = port_en[1];
	assign test_port_en = port_en[2];
	assign skip_erase_sel = mode_q[FNC_MODE_SKIP_ER];
	assign wait_state_count = mode_q[FNC_MODE_WS_LO +: 2];
	assign rd_cycles = rdc_q;
	assign wr_cycles = wrc_q;
endmodule
`default_nettype wire

//--- verification/fnc_flash_ctrl_props.sv
// Port-level assertions for the flash nv bit controller
`timescale 1ns/1ns
`default_nettype none
module fnc_flash_ctrl_props (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        erase_req,
	input wire logic        array_rd_req,
	input wire logic        array_rd_ack,
	input wire logic        fc_irq,
	input wire logic        debug_port_en,
	input wire logic        skip_erase_sel,
	input wire logic [1:0]  wait_state_count,
	input wire logic [2:0]  rd_cycles,
	input wire logic [2:0]  wr_cycles
);
	logic [31:0] mode_q;
	logic [2:0]  up_q;
	// Mode shadow; up_q masks the settling edges after reset
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mode_q <= 32'h0;
			up_q   <= 3'h0;
		end else begin
			if (psel && penable && pready && pwrite && paddr == 8'h60)
				mode_q <= pwdata & 32'h00ff_038d;
			if (up_q != 3'h7)
				up_q <= up_q + 3'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_ack_follows: assert property (
		up_q == 3'h7 |=> array_rd_ack == $past(array_rd_req))
		else $error("array read ack wrong");
	a_ws_decode: assert property (
		up_q == 3'h7 |-> rd_cycles == {1'b0, $past(wait_state_count)} + 3'h1 &&
		wr_cycles == ($past(wait_state_count) == 2'h3 ? 3'h4 : {1'b0, $past(wait_state_count)} + 3'h2))
		else $error("wait state decode wrong");
	a_ready_answer: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer timing wrong");
	a_unmapped_err: assert property (
		pready |-> pslverr == !(paddr inside {8'h60, 8'h64, 8'h68, 8'h6c}))
		else $error("slave error wrong");
	a_mode_fields: assert property (
		!psel |-> skip_erase_sel == mode_q[7] && wait_state_count == mode_q[9:8])
		else $error("mode outputs wrong");
	a_irq_enabled: assert property (
		fc_irq |-> ((mode_q | $past(mode_q)) & 32'hd) != 32'h0)
		else $error("interrupt without enable");
	a_cmd_drops_ready: assert property (
		pready && pwrite && paddr == 8'h64 && pwdata[31:24] == 8'h5a && fc_irq &&
		pwdata[3:0] inside {4'hb, 4'hd, 4'hf} && mode_q[3:0] == 4'h1 |-> ##[1:3] !fc_irq)
		else $error("ready not cleared by command");
	a_sec_only_erase: assert property (
		$rose(debug_port_en) && up_q == 3'h7 |-> erase_req)
		else $error("security left without erase");
endmodule
bind fnc_flash_ctrl fnc_flash_ctrl_props fnc_flash_ctrl_props_i (.*);
`default_nettype wire

//--- verification/fnc_array_model.sv
// Flash array side: keeps issuing reads and counts any left unanswered
`timescale 1ns/1ns
`default_nettype none
module fnc_array_model (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic array_rd_ack,
	output logic      array_rd_req,
	output int        misses
);
	logic [2:0] ph_q = 3'h0;
	logic       req_q = 1'b0;
	initial misses = 0;
	// Reads never pause for nv work in progress
	assign array_rd_req = ph_q != 3'h5;
	always @(posedge clk) begin
		ph_q  <= ph_q + 3'h1;
		req_q <= array_rd_req & rst_b;
		if (req_q && array_rd_ack !== 1'b1)
			misses <= misses + 1;
	end
endmodule
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the flash nv bit controller
`timescale 1ns/1ns
`default_nettype none
module tb;
	import fnc_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        erase_req = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        slv;
	logic        array_rd_req;
	logic        array_rd_ack;
	logic        fc_irq;
	logic        debug_port_en;
	logic        fast_prog_en;
	logic        test_port_en;
	logic        skip_erase_sel;
	logic [1:0]  wait_state_count;
	logic [2:0]  rd_cycles;
	logic [2:0]  wr_cycles;
	int          misses;
	int          errors = 0;
	int          checks_done = 0;
	// 100 clock cycles in one microsecond at 100 MHz
	localparam logic [31:0] MODE_BASE = 32'h0064_0000;
	fnc_flash_ctrl fnc_flash_ctrl_i (.*);
	fnc_array_model fnc_array_model_i (.*);
	always #5 clk = ~clk;
	task automatic final_report;
		if (errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			errors++;
			final_report();
		end
		rd = prdata;
		slv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Idle edge keeps two tasks from driving psel in one step
		@(posedge clk);
	endtask
	task automatic cmd(input logic [3:0] code, input logic [7:0] idx, key);
		apb(1'b1, FNC_OFS_CMD, {key, 8'h0, idx, 4'h0, code});
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			apb(1'b0, FNC_OFS_STATUS, 32'h0);
			n++;
		end while (rd[FNC_ST_RDY] !== 1'b1 && n < 1000);
		if (rd[FNC_ST_RDY] !== 1'b1) begin
			errors++;
			final_report();
		end
	endtask
	function automatic logic [31:0] st(input logic [1:0] gp, input logic sec);
		return {22'h0, gp, 3'h0, sec, 4'h1};
	endfunction
	task automatic t_reset;
		apb(1'b0, FNC_OFS_MODE, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, FNC_OFS_STATUS, 32'h0);
		chk(rd, st(2'b00, 1'b0));
		apb(1'b0, 8'h70, 32'h0);
		chk({31'h0, slv}, 32'h1);
		apb(1'b1, FNC_OFS_RSVD, 32'h0);
		chk({31'h0, slv}, 32'h0);
		chk({29'h0, debug_port_en, fast_prog_en, test_port_en}, 32'h7);
	endtask
	task automatic t_mode;
		apb(1'b1, FNC_OFS_MODE, 32'hffff_ffff);
		apb(1'b0, FNC_OFS_MODE, 32'h0);
		chk(rd, 32'h00ff_038d);
		chk({31'h0, skip_erase_sel}, 32'h1);
		for (int ws = 0; ws < 4; ws++) begin
			apb(1'b1, FNC_OFS_MODE, MODE_BASE | 32'h1 | (ws << 8));
			@(posedge clk);
			chk({26'h0, rd_cycles, wr_cycles}, (ws + 1) * 8 + (ws == 3 ? 4 : ws + 2));
		end
		apb(1'b1, FNC_OFS_MODE, MODE_BASE | 32'h1);
	endtask
	task automatic t_gp;
		cmd(FNC_CMD_SET_GP, 8'h1, FNC_CMD_KEY);
		apb(1'b0, FNC_OFS_STATUS, 32'h0);
		chk({31'h0, rd[FNC_ST_RDY]}, 32'h0);
		wait_ready();
		chk(rd, st(2'b10, 1'b0));
		chk({31'h0, fc_irq}, 32'h1);
		cmd(FNC_CMD_SET_GP, 8'h0, FNC_CMD_KEY);
		wait_ready();
		chk(rd, st(2'b11, 1'b0));
		cmd(FNC_CMD_CLR_GP, 8'h1, FNC_CMD_KEY);
		wait_ready();
		chk(rd, st(2'b01, 1'b0));
		cmd(FNC_CMD_CLR_GP, 8'h2, FNC_CMD_KEY);
		wait_ready();
		chk(rd, st(2'b01, 1'b0));
	endtask
	task automatic t_err;
		apb(1'b1, FNC_OFS_MODE, MODE_BASE | 32'h8);
		cmd(FNC_CMD_SET_GP, 8'h1, 8'h5b);
		repeat (2) @(posedge clk);
		chk({31'h0, fc_irq}, 32'h1);
		apb(1'b0, FNC_OFS_STATUS, 32'h0);
		chk(rd, st(2'b01, 1'b0) | 32'h8);
		apb(1'b0, FNC_OFS_STATUS, 32'h0);
		chk(rd, st(2'b01, 1'b0));
		chk({31'h0, fc_irq}, 32'h0);
		cmd(FNC_CMD_NONE, 8'h0, FNC_CMD_KEY);
		apb(1'b0, FNC_OFS_STATUS, 32'h0);
		chk(rd, st(2'b01, 1'b0));
		cmd(4'h1, 8'h0, FNC_CMD_KEY);
		apb(1'b0, FNC_OFS_STATUS, 32'h0);
		chk(rd, st(2'b01, 1'b0) | 32'h8);
		apb(1'b1, FNC_OFS_MODE, MODE_BASE | 32'h1);
	endtask
	task automatic t_sec;
		cmd(FNC_CMD_SET_SEC, 8'h0, FNC_CMD_KEY);
		wait_ready();
		chk(rd, st(2'b01, 1'b1));
		chk({29'h0, debug_port_en, fast_prog_en, test_port_en}, 32'h0);
		cmd(FNC_CMD_CLR_GP, 8'h0, FNC_CMD_KEY);
		wait_ready();
		chk(rd, st(2'b00, 1'b1));
		erase_req <= 1'b1;
		// Let the erase start before polling for ready
		repeat (3) @(posedge clk);
		wait_ready();
		chk(rd, st(2'b00, 1'b0));
		chk({29'h0, debug_port_en, fast_prog_en, test_port_en}, 32'h7);
		erase_req <= 1'b0;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_reset();
		t_mode();
		t_gp();
		t_err();
		t_sec();
		chk(misses, 32'h0);
		final_report();
	end
endmodule
`default_nettype wire
